// ==== rtl/esra_pkg.sv ====
/*
 * Shared constants and types of the engine speed request arbiter.
 * Assumes a single 100 MHz clock and a 50 Hz scan of the request logic.
 */
package esra_pkg;

   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int SCAN_HZ = 50;
   localparam int SCAN_CYCLES = CLK_HZ / SCAN_HZ;

   // ************************************************
   // Interlock and example limits
   // ************************************************
   localparam logic [7:0] ROAD_LIMIT_MPH = 8'h03;
   localparam logic [15:0] TACH_LIMIT_RPM = 16'h0578;
   localparam logic [15:0] RPM_RST = 16'h0000;

   // ************************************************
   // User end register map (AXI4-Lite)
   // ************************************************
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_CMD = 4'h4;
   localparam logic [3:0] OFF_STAT = 4'h8;
   localparam logic [3:0] OFF_LIMIT = 4'hc;
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam int CTRL_VAR = 0;
   localparam int CTRL_RAISE = 1;
   localparam int CTRL_LOWER = 2;
   localparam int CMD_UP = 0;
   localparam int CMD_DOWN = 1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ************************************************
   // Device states
   // ************************************************
   typedef enum logic [1:0] {
      ESRA_OFF = 2'b00,
      ESRA_RAMP = 2'b01,
      ESRA_HOLD = 2'b10,
      ESRA_STEP = 2'b11
   } esra_state_t;

endpackage

// ==== rtl/esra_link_if.sv ====
/*
 * Request link between user ladder logic and the body system controller.
 * Both ends are clocked by the same aclk; no clocking block.
 */
`timescale 1ns/100ps
interface esra_link_if;
   logic speed_req;
   logic func1_req;
   logic func2_req;
   logic inhibited;

   modport user_end (output speed_req, output func1_req, output func2_req, input inhibited);
   modport dev_end (input speed_req, input func1_req, input func2_req, output inhibited);
endinterface // esra_link_if

// ==== rtl/esra_scan_tick.sv ====
/*
 * Scan divider: one-cycle enable every PERIOD clocks.
 * Assumes PERIOD of at least 2.
 */
`timescale 1ns/100ps
module esra_scan_tick
   import esra_pkg::*;
#(
   parameter int PERIOD = SCAN_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Scan enable
   output logic tick
);
   localparam int W = $clog2(PERIOD);
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);

   logic [W-1:0] cnt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt == LAST);
         cnt <= (cnt == LAST) ? '0 : cnt + W'(1);
      end
   end
endmodule // esra_scan_tick

// ==== rtl/esra_device.sv ====
/*
 * Body system controller end: arbitrates ladder logic speed requests,
 * keeps the lockout flag and commands engine speed.
 * Assumes vehicle inputs already synchronous to aclk and user logic
 * on the user_end of esra_link_if.
 */
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps

// Overview of operation
// - Request held: cruise enabled, others locked out
// - Request dropped: cruise enable off
// - User holds request whole control interval
// - After lockout, request must drop then rise
// - Other interface active: lockout, ignore requests
// - Lockout on speed, park brake, brake pedal
// - Automatic out of neutral locks out
// - Bad interlock status locks out
// - Fixed mode: set edge ramps to target 1
// - Fixed mode: resume edge ramps to target 2
// - Variable mode: set lowers by decrement step
// - Variable mode: resume raises by increment step
// - Requests evaluated fifty times per second
// - User limits raise, uses small step
// - Fixed example: one latch drives request, set
// - Variable example latch set/clear sources
// - Variable example: requests gated by latch
// - Raise blocked at tachometer limit 1400
// - Request during conflict sets lockout flag
// - Configured: cab enable, mode, rate, targets
module esra_device
   import esra_pkg::*;
#(
   parameter int SCAN_PERIOD = SCAN_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link to user logic
   esra_link_if.dev_end link,
   // Vehicle interlocks
   input wire logic other_ctl,
   input wire logic park_brake_set,
   input wire logic brake_pedal,
   input wire logic [7:0] road_speed,
   input wire logic auto_trans,
   input wire logic in_neutral,
   input wire logic interlock_bad,
   // Engine configuration
   input wire logic cab_enable,
   input wire logic variable_mode,
   input wire logic [15:0] ramp_rate,
   input wire logic [15:0] target1_rpm,
   input wire logic [15:0] target2_rpm,
   input wire logic [15:0] step_up,
   input wire logic [15:0] step_down,
   input wire logic [15:0] idle_rpm,
   input wire logic [15:0] max_rpm,
   // Engine commands
   output logic cruise_enable,
   output logic lockout_others,
   output logic [15:0] rpm_cmd
);

   // ************************************************
   // Scan enable
   // ************************************************
   logic tick;

   esra_scan_tick #(
      .PERIOD(SCAN_PERIOD)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   // ************************************************
   // Lockout decision
   // ************************************************
   logic lock_cond;
   logic inhib;
   logic granted;

   always_comb begin
      lock_cond = other_ctl;
      lock_cond = lock_cond | (road_speed > ROAD_LIMIT_MPH);
      lock_cond = lock_cond | !park_brake_set | brake_pedal;
      lock_cond = lock_cond | (auto_trans & !in_neutral);
      lock_cond = lock_cond | interlock_bad;
   end

   // Flag stays set until the lock cause is gone and the user drops
   // the request, so a held request can never silently regain control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         inhib <= 1'b0;
      end else if (tick) begin
         if (lock_cond) begin
            inhib <= 1'b1;
         end else if (!link.speed_req) begin
            inhib <= 1'b0;
         end
      end
   end

   assign link.inhibited = inhib;

   assign granted = cab_enable & link.speed_req & !inhib & !lock_cond;

   // ************************************************
   // Cruise enable and lockout of other sources
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cruise_enable <= 1'b0;
         lockout_others <= 1'b0;
      end else if (tick) begin
         cruise_enable <= granted;
         lockout_others <= granted;
      end
   end

   // ************************************************
   // Scan-to-scan edge detection
   // ************************************************
   logic prev_f1;
   logic prev_f2;
   logic rise1;
   logic rise2;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_f1 <= 1'b0;
         prev_f2 <= 1'b0;
      end else if (tick) begin
         prev_f1 <= link.func1_req;
         prev_f2 <= link.func2_req;
      end
   end

   assign rise1 = link.func1_req & !prev_f1;
   assign rise2 = link.func2_req & !prev_f2;

   // ************************************************
   // Ramp step toward a fixed target
   // ************************************************
   logic [15:0] ramp_step;
   logic [15:0] target;
   logic [15:0] next_rpm;

   always_comb begin
      ramp_step = 16'(ramp_rate / SCAN_HZ);
      if (ramp_step == 16'h0000) begin
         ramp_step = 16'h0001;
      end
      if (rpm_cmd < target) begin
         next_rpm = (target - rpm_cmd > ramp_step) ? rpm_cmd + ramp_step : target;
      end else begin
         next_rpm = (rpm_cmd - target > ramp_step) ? rpm_cmd - ramp_step : target;
      end
   end

   // ************************************************
   // Variable steps, clamped to idle and governed speed
   // ************************************************
   logic [15:0] lower_rpm;
   logic [15:0] raise_rpm;

   always_comb begin
      if ({1'b0, rpm_cmd} >= {1'b0, idle_rpm} + {1'b0, step_down}) begin
         lower_rpm = rpm_cmd - step_down;
      end else begin
         lower_rpm = idle_rpm;
      end
      if ({1'b0, rpm_cmd} + {1'b0, step_up} <= {1'b0, max_rpm}) begin
         raise_rpm = rpm_cmd + step_up;
      end else begin
         raise_rpm = max_rpm;
      end
   end

   // ************************************************
   // Speed control state machine, one step per scan
   // ************************************************
   esra_state_t state;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ESRA_OFF;
         rpm_cmd <= RPM_RST;
         target <= RPM_RST;
      end else if (tick) begin
         if (!granted) begin
            state <= ESRA_OFF;
            rpm_cmd <= idle_rpm;
            target <= idle_rpm;
         end else begin
            case (state)
               ESRA_OFF: begin
                  rpm_cmd <= idle_rpm;
                  if (variable_mode) begin
                     state <= ESRA_STEP;
                  end else if (rise1) begin
                     target <= target1_rpm;
                     state <= ESRA_RAMP;
                  end else if (rise2) begin
                     target <= target2_rpm;
                     state <= ESRA_RAMP;
                  end else begin
                     target <= idle_rpm;
                     state <= ESRA_HOLD;
                  end
               end
               ESRA_RAMP, ESRA_HOLD: begin
                  // Target latched, so the request need not be held
                  if (variable_mode) begin
                     state <= ESRA_STEP;
                  end else if (rise1) begin
                     target <= target1_rpm;
                     state <= ESRA_RAMP;
                  end else if (rise2) begin
                     target <= target2_rpm;
                     state <= ESRA_RAMP;
                  end else begin
                     rpm_cmd <= next_rpm;
                     state <= (next_rpm == target) ? ESRA_HOLD : ESRA_RAMP;
                  end
               end
               ESRA_STEP: begin
                  // Lower wins when both are held: the safer direction
                  if (!variable_mode) begin
                     target <= rpm_cmd;
                     state <= ESRA_HOLD;
                  end else if (link.func1_req) begin
                     rpm_cmd <= lower_rpm;
                  end else if (link.func2_req) begin
                     rpm_cmd <= raise_rpm;
                  end
               end
               default: begin
                  state <= ESRA_OFF;
               end
            endcase
         end
      end
   end

endmodule // esra_device

// ==== rtl/esra_user.sv ====
/*
 * User ladder logic end: builds enable, set and resume requests from
 * software commands and remote inputs, following the two examples.
 * Assumes an AXI4-Lite master and the device on the link's far side.
 */
`timescale 1ns/100ps
module esra_user
   import esra_pkg::*;
#(
   parameter int SCAN_PERIOD = SCAN_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Remote input and tachometer
   input wire logic remote_hi,
   input wire logic remote_gnd,
   input wire logic [15:0] engine_rpm,
   // Link to device
   esra_link_if.user_end link
);

   // ************************************************
   // Write path
   // ************************************************
   logic [ADDR_W-1:0] waddr;
   logic [31:0] wval;
   logic [3:0] wmask;
   logic wr_fire;
   logic [4:0] ctrl;
   logic [15:0] limit;
   logic up_pend;
   logic down_pend;
   logic tick;

   assign wr_fire = !awready & !wready & !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         waddr <= '0;
         wval <= '0;
         wmask <= '0;
      end else begin
         if (awvalid & awready) begin
            awready <= 1'b0;
            waddr <= awaddr;
         end
         if (wvalid & wready) begin
            wready <= 1'b0;
            wval <= wdata;
            wmask <= wstrb;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (waddr == OFF_STAT) ? RESP_SLVERR : RESP_OKAY;
         end
         if (bvalid & bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RST;
         limit <= TACH_LIMIT_RPM;
      end else if (wr_fire) begin
         if (waddr == OFF_CTRL) begin
            if (wmask[0]) ctrl <= wval[4:0];
         end else if (waddr == OFF_LIMIT) begin
            if (wmask[0]) limit[7:0] <= wval[7:0];
            if (wmask[1]) limit[15:8] <= wval[15:8];
         end
      end
   end

   // Switch presses wait for the next scan; a press in the scan
   // cycle itself survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_pend <= 1'b0;
         down_pend <= 1'b0;
      end else begin
         up_pend <= (up_pend & !tick) |
                    (wr_fire & (waddr == OFF_CMD) & wmask[0] & wval[CMD_UP]);
         down_pend <= (down_pend & !tick) |
                      (wr_fire & (waddr == OFF_CMD) & wmask[0] & wval[CMD_DOWN]);
      end
   end

   // ************************************************
   // Read path
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid & arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= RESP_OKAY;
         if (araddr == OFF_CTRL) begin
            rdata <= {27'h0000000, ctrl};
         end else if (araddr == OFF_CMD) begin
            rdata <= {30'h00000000, down_pend, up_pend};
         end else if (araddr == OFF_STAT) begin
            rdata <= {28'h0000000, link.inhibited, link.func2_req, link.func1_req,
                      link.speed_req};
         end else if (araddr == OFF_LIMIT) begin
            rdata <= {16'h0000, limit};
         end else begin
            rdata <= '0;
            rresp <= RESP_SLVERR;
         end
      end else if (rvalid & rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ************************************************
   // Ladder scan
   // ************************************************
   logic latch;
   logic f1;
   logic f2;

   esra_scan_tick #(
      .PERIOD(SCAN_PERIOD)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   // Clear wins: lockout must force the request low so it can rise again
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch <= 1'b0;
         f1 <= 1'b0;
         f2 <= 1'b0;
      end else if (tick) begin
         if (down_pend | link.inhibited | (ctrl[CTRL_VAR] & remote_gnd)) begin
            latch <= 1'b0;
         end else if (up_pend | (ctrl[CTRL_VAR] & remote_hi)) begin
            latch <= 1'b1;
         end
         if (ctrl[CTRL_VAR]) begin
            f1 <= latch & ctrl[CTRL_LOWER];
            f2 <= latch & ctrl[CTRL_RAISE] & (engine_rpm < limit);
         end else begin
            f1 <= latch;
            f2 <= 1'b0;
         end
      end
   end

   assign link.speed_req = latch;
   assign link.func1_req = f1;
   assign link.func2_req = f2;

endmodule // esra_user

// ==== test/esra_chk.sv ====
/* Watches the request link and the engine outputs.
   Assumes the bench wires it beside the link with matching names. */
`timescale 1ns/100ps
module esra_chk
   import esra_pkg::*;
#(
   parameter int SCAN_PERIOD = 20
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link
   input wire logic speed_req,
   input wire logic inhibited,
   // Interlocks
   input wire logic other_ctl,
   input wire logic park_brake_set,
   input wire logic brake_pedal,
   input wire logic [7:0] road_speed,
   input wire logic auto_trans,
   input wire logic in_neutral,
   input wire logic interlock_bad,
   input wire logic cab_enable,
   // Engine
   input wire logic cruise_enable,
   input wire logic lockout_others,
   input wire logic [15:0] rpm_cmd
);
   localparam int LIM = SCAN_PERIOD + 2;
   logic lock;
   logic rel_ok;
   logic grant_ok;
   int lock_cnt;
   int gap_cnt;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   assign lock = other_ctl | ~park_brake_set | brake_pedal | (road_speed > ROAD_LIMIT_MPH)
      | (auto_trans & ~in_neutral) | interlock_bad;
   assign rel_ok = ~speed_req & ~lock;
   assign grant_ok = speed_req & ~lock & cab_enable & ~inhibited;

   // Lock present, flag low: must end at the next scan
   always_ff @(posedge aclk) begin
      if (!aresetn || !lock || inhibited) begin
         lock_cnt <= 0;
      end else begin
         lock_cnt <= lock_cnt + 1;
      end
   end

   // rpm_cmd left out: outside reset it too changes only on scans
   always_ff @(posedge aclk) begin
      if (!aresetn || $changed({cruise_enable, inhibited})) begin
         gap_cnt <= 0;
      end else begin
         gap_cnt <= gap_cnt + 1;
      end
   end

   a_cruise_pair: assert property (cruise_enable == lockout_others)
      else $error("cruise enable and lockout differ");
   a_drop_off: assert property ($fell(speed_req) |-> ##[0:LIM] !cruise_enable)
      else $error("cruise stayed on after request drop");
   a_flag_blocks: assert property (inhibited |-> !cruise_enable)
      else $error("cruise on while flagged");
   a_flag_cause: assert property ($rose(inhibited) |-> $past(lock))
      else $error("flag rose without lock cause");
   a_flag_release: assert property ($fell(inhibited) |-> $past(rel_ok))
      else $error("flag cleared too early");
   a_grant_cause: assert property ($rose(cruise_enable) |-> $past(grant_ok))
      else $error("cruise granted without clean request");
   a_lock_bounded: assert property (lock_cnt <= LIM)
      else $error("lock cause not flagged within a scan");
   a_scan_spacing: assert property ($changed({cruise_enable, inhibited})
      |-> gap_cnt >= SCAN_PERIOD - 1)
      else $error("link outputs changed between scans");
endmodule // esra_chk

// ==== test/tb_top.sv ====
/* Bench joining user and device ends over the link.
   Assumes a scan period shortened to P clocks. */
`timescale 1ns/100ps
module tb_top
   import esra_pkg::*;
   ;
   localparam int P = 20;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, remote_hi = 1'b0, remote_gnd = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
   logic [31:0] wdata = 32'h0;
   logic other_ctl = 1'b0, park_brake_set = 1'b1, brake_pedal = 1'b0, auto_trans = 1'b0;
   logic in_neutral = 1'b1, interlock_bad = 1'b0, cab_enable = 1'b1, variable_mode = 1'b0;
   logic [7:0] road_speed = 8'h00;
   logic [15:0] engine_rpm = 16'h0, ramp_rate = 16'h0, target1_rpm = 16'h0;
   logic [15:0] target2_rpm = 16'h0, step_up = 16'h0, step_down = 16'h0;
   logic [15:0] idle_rpm = 16'h0, max_rpm = 16'h0;
   logic awready, wready, bvalid, arready, rvalid, cruise_enable, lockout_others;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] rpm_cmd;
   int n_errors = 0, checks_done = 0, cyc = 0;

   esra_link_if link();
   esra_device #(.SCAN_PERIOD(P)) esra_device_i (.*);
   esra_user #(.SCAN_PERIOD(P)) esra_user_i (.*);
   esra_chk #(.SCAN_PERIOD(P)) esra_chk_i (.*, .speed_req(link.speed_req),
      .inhibited(link.inhibited));

   always #5 aclk = ~aclk;

   // Tachometer echoes the command; cycle ceiling
   always @(posedge aclk) begin
      engine_rpm <= rpm_cmd;
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         n_errors++;
         final_report();
      end
   end

   // ********************
   // Helpers
   // ********************
   task automatic final_report();
      $display("Errors %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er}, "bresp");
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, e, "rdata");
      chk({30'h0, rresp}, {30'h0, er}, "rresp");
   endtask

   task automatic ticks(input int n);
      repeat (n * P) @(negedge aclk);
   endtask

   // Causes 0..5 lock out; 6 is road speed at the limit, 7 a manual gearbox
   function automatic logic lock_exp(input int k);
      return k < 6;
   endfunction

   task automatic cause(input int k, input logic on);
      @(posedge aclk);
      case (k)
         0: other_ctl <= on;
         1: park_brake_set <= !on;
         2: brake_pedal <= on;
         3: road_speed <= on ? 8'h04 + 8'($urandom % 200) : 8'h00;
         4: begin
            auto_trans <= on;
            in_neutral <= !on;
         end
         5: interlock_bad <= on;
         6: road_speed <= on ? ROAD_LIMIT_MPH : 8'h00;
         default: in_neutral <= !on;
      endcase
   endtask

   task automatic wait_rpm(input logic [15:0] v);
      int n;
      n = 0;
      while (rpm_cmd !== v && n < 30000) begin
         @(negedge aclk);
         n++;
      end
   endtask

   task automatic wait_chg(output int n);
      logic [15:0] v;
      v = rpm_cmd;
      n = 0;
      while (rpm_cmd === v && n < 1000) begin
         @(negedge aclk);
         n++;
      end
   endtask

   function automatic logic [15:0] nxt(input logic [15:0] v, input logic up);
      if (up) begin
         return (v > max_rpm - step_up) ? max_rpm : v + step_up;
      end
      return (v < idle_rpm + step_down) ? idle_rpm : v - step_down;
   endfunction

   task automatic step_chk(input logic up);
      int n;
      logic [15:0] v;
      wait_chg(n);
      v = rpm_cmd;
      wait_chg(n);
      chk(rpm_cmd, nxt(v, up), "step");
      chk(n, P, "scan gap");
   endtask

   // ********************
   // Main sequence
   // ********************
   initial begin
      logic [15:0] idl;
      logic [15:0] lim;
      void'($urandom(92));
      @(posedge aclk);
      idl = 16'd600 + 16'($urandom % 200);
      idle_rpm <= idl;
      max_rpm <= idl + 16'd400 + 16'($urandom % 400);
      step_up <= 16'd5 + 16'($urandom % 40);
      step_down <= 16'd5 + 16'($urandom % 40);
      target1_rpm <= idl + 16'd100 + 16'($urandom % 400);
      target2_rpm <= idl + 16'd100 + 16'($urandom % 400);
      ramp_rate <= 16'd50 * (16'd1 + 16'($urandom % 30));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(OFF_CTRL, 32'h0, RESP_OKAY);
      rdchk(OFF_LIMIT, {16'h0, TACH_LIMIT_RPM}, RESP_OKAY);
      rdchk(4'h6, 32'h0, RESP_SLVERR);
      axw(OFF_STAT, 32'hf, RESP_SLVERR);
      axw(4'h6, 32'hf, RESP_OKAY);
      rdchk(OFF_STAT, 32'h0, RESP_OKAY);
      cab_enable <= 1'b0;
      axw(OFF_CMD, 32'h1, RESP_OKAY);
      ticks(3);
      chk(cruise_enable, 1'b0, "cab off");
      axw(OFF_CMD, 32'h2, RESP_OKAY);
      ticks(2);
      @(posedge aclk);
      cab_enable <= 1'b1;
      axw(OFF_CMD, 32'h1, RESP_OKAY);
      wait_rpm(target1_rpm);
      chk(rpm_cmd, target1_rpm, "target 1");
      chk(cruise_enable, 1'b1, "granted");
      // Variable example against a fixed engine gives a resume edge
      axw(OFF_LIMIT, 32'hffff, RESP_OKAY);
      axw(OFF_CTRL, 32'h3, RESP_OKAY);
      wait_rpm(target2_rpm);
      chk(rpm_cmd, target2_rpm, "target 2");
      axw(OFF_CTRL, 32'h0, RESP_OKAY);
      for (int k = 0; k < 8; k++) begin
         cause(k, 1'b1);
         ticks(2);
         chk(link.inhibited, lock_exp(k), "flag");
         chk(cruise_enable, !lock_exp(k), "cruise");
         cause(k, 1'b0);
         ticks(3);
         chk(link.inhibited, 1'b0, "flag off");
         if (lock_exp(k)) begin
            axw(OFF_CMD, 32'h1, RESP_OKAY);
            ticks(3);
         end
         chk(cruise_enable, 1'b1, "regain");
      end
      // Start the steps well above idle so two lowers both move
      wait_rpm(target1_rpm);
      chk(rpm_cmd, target1_rpm, "target 1 again");
      @(posedge aclk);
      variable_mode <= 1'b1;
      axw(OFF_CTRL, 32'h5, RESP_OKAY);
      step_chk(1'b0);
      wait_rpm(idle_rpm);
      chk(rpm_cmd, idle_rpm, "idle clamp");
      axw(OFF_CTRL, 32'h3, RESP_OKAY);
      step_chk(1'b1);
      wait_rpm(max_rpm);
      chk(rpm_cmd, max_rpm, "max clamp");
      lim = idle_rpm + 16'd100;
      axw(OFF_LIMIT, {16'h0, lim}, RESP_OKAY);
      axw(OFF_CTRL, 32'h5, RESP_OKAY);
      wait_rpm(idle_rpm);
      axw(OFF_CTRL, 32'h3, RESP_OKAY);
      ticks(40);
      chk(rpm_cmd >= lim && rpm_cmd < lim + 16'd2 * step_up, 1'b1, "limit");
      rdchk(OFF_STAT, 32'h1, RESP_OKAY);
      @(posedge aclk);
      remote_gnd <= 1'b1;
      ticks(3);
      chk(cruise_enable, 1'b0, "grounded");
      @(posedge aclk);
      remote_gnd <= 1'b0;
      remote_hi <= 1'b1;
      ticks(3);
      chk(cruise_enable, 1'b1, "remote on");
      @(posedge aclk);
      remote_hi <= 1'b0;
      axw(OFF_CMD, 32'h2, RESP_OKAY);
      ticks(3);
      chk(cruise_enable, 1'b0, "switch down");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(negedge aclk);
      chk(rpm_cmd, RPM_RST, "reset rpm");
      @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(OFF_CTRL, 32'h0, RESP_OKAY);
      final_report();
   end
endmodule // tb_top
